// [shared/pru_map.svh]
// register map, field positions, reset values and pin positions of the pin route unit
`ifndef PRU_MAP_SVH
`define PRU_MAP_SVH

// =====================================================================
// register indices (byte address is four times the index)
`define PRU_IDX_EVENT 6'h00
`define PRU_IDX_CELL 6'h01
`define PRU_IDX_SERIAL 6'h02
`define PRU_IDX_TWOSYNC 6'h03
`define PRU_IDX_TIMER_A 6'h04
`define PRU_IDX_TIMER_B 6'h05

// =====================================================================
// implemented bits of each register
`define PRU_MASK_EVENT 8'h3f
`define PRU_MASK_CELL 8'h0f
`define PRU_MASK_SERIAL 8'hff
`define PRU_MASK_TWOSYNC 8'h33
`define PRU_MASK_TIMER_A 8'h07
`define PRU_MASK_TIMER_B 8'h0f

// =====================================================================
// reset value of every route register
`define PRU_RST_ROUTE 8'h00

// =====================================================================
// field positions
`define PRU_SYNC_SER_POS 0
`define PRU_TWO_WIRE_POS 4
`define PRU_TIMER_A_POS 0

// =====================================================================
// port indices and pin positions
`define PRU_PORT_A 3'h0
`define PRU_PORT_B 3'h1
`define PRU_PORT_C 3'h2
`define PRU_PORT_D 3'h3
`define PRU_PORT_E 3'h4
`define PRU_PORT_F 3'h5
`define PRU_EV_PIN_DEF 3'h2
`define PRU_EV_PIN_ALT 3'h7
`define PRU_CELL_PIN_DEF 3'h3
`define PRU_CELL_PIN_ALT 3'h6
`define PRU_ALT_LANE_BASE 3'h4
`define PRU_TWO_WIRE_BASE 3'h2
`define PRU_TIMER_A_LAST 3'h5

`endif

// [shared/pru_pkg.sv]
// types shared by the pin route unit files
package pru_pkg;

    // =================================================================
    // up to four signal lanes of one peripheral
    typedef struct packed {
        logic [3:0] val;
        logic [3:0] oe;
    } pru_lane4_t;

    // =================================================================
    // the six route registers
    typedef struct packed {
        logic [7:0] event_route;
        logic [7:0] cell_route;
        logic [7:0] serial_route;
        logic [7:0] twosync_route;
        logic [7:0] timer_a_route;
        logic [7:0] timer_b_route;
    } pru_route_cfg_t;

    // =================================================================
    // two-bit location codes
    typedef enum logic [1:0] {
        PRU_LOC_DEFAULT = 2'b00,
        PRU_LOC_ALTERNATE_FIRST = 2'b01,
        PRU_LOC_ALTERNATE_SECOND = 2'b10,
        PRU_LOC_NONE = 2'b11
    } pru_loc_t;

    // bus slave states
    typedef enum logic [0:0] {
        PRU_BUS_IDLE = 1'b0,
        PRU_BUS_ACK = 1'b1
    } pru_bus_state_t;

endpackage : pru_pkg

// [hw/pru_reg_bank.sv]
// wishbone slave holding the six route registers
`timescale 1ns/1ns
`include "pru_map.svh"

module pru_reg_bank
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output pru_pkg::pru_route_cfg_t cfg_o
);

    // =================================================================
    // decoding
    // implemented-bit mask of a register index, zero when unmapped
    function automatic logic [7:0] reg_mask(input logic [5:0] idx);
        case (idx)
            `PRU_IDX_EVENT: reg_mask = `PRU_MASK_EVENT;
            `PRU_IDX_CELL: reg_mask = `PRU_MASK_CELL;
            `PRU_IDX_SERIAL: reg_mask = `PRU_MASK_SERIAL;
            `PRU_IDX_TWOSYNC: reg_mask = `PRU_MASK_TWOSYNC;
            `PRU_IDX_TIMER_A: reg_mask = `PRU_MASK_TIMER_A;
            `PRU_IDX_TIMER_B: reg_mask = `PRU_MASK_TIMER_B;
            default: reg_mask = 8'h00;
        endcase
    endfunction : reg_mask

    pru_pkg::pru_bus_state_t state_ff, nxt_state;
    logic [7:0] regs_ff [6];
    logic [7:0] nxt_regs [6];
    logic [31:0] dat_ff, nxt_dat;
    logic [5:0] idx;
    logic [7:0] mask;
    logic take;

    assign idx = wb_adr_i[7:2];
    assign mask = reg_mask(idx);
    assign take = wb_cyc_i && wb_stb_i && (state_ff == pru_pkg::PRU_BUS_IDLE);

    // =================================================================
    // next state: write on take, ack one cycle later for one cycle
    always_comb
    begin
        nxt_state = state_ff;
        nxt_dat = dat_ff;
        for (int i = 0; i < 6; i++)
        begin
            nxt_regs[i] = regs_ff[i];
        end
        case (state_ff)
            pru_pkg::PRU_BUS_IDLE:
            begin
                if (take)
                begin
                    nxt_state = pru_pkg::PRU_BUS_ACK;
                    nxt_dat = '0;
                    if (mask != 8'h00)
                    begin
                        nxt_dat = {24'h000000, regs_ff[idx[2:0]] & mask};
                        if (wb_we_i && wb_sel_i[0])
                        begin
                            nxt_regs[idx[2:0]] = wb_dat_i[7:0] & mask;
                        end
                    end
                end
            end
            pru_pkg::PRU_BUS_ACK: nxt_state = pru_pkg::PRU_BUS_IDLE;
            default: nxt_state = pru_pkg::PRU_BUS_IDLE;
        endcase
    end

    // registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_ff <= pru_pkg::PRU_BUS_IDLE;
            dat_ff <= 32'h00000000;
            for (int i = 0; i < 6; i++)
            begin
                regs_ff[i] <= `PRU_RST_ROUTE;
            end
        end
        else
        begin
            state_ff <= nxt_state;
            dat_ff <= nxt_dat;
            for (int i = 0; i < 6; i++)
            begin
                regs_ff[i] <= nxt_regs[i];
            end
        end
    end

    assign wb_ack_o = (state_ff == pru_pkg::PRU_BUS_ACK);
    assign wb_dat_o = dat_ff;
    assign cfg_o = '{regs_ff[0], regs_ff[1], regs_ff[2], regs_ff[3], regs_ff[4], regs_ff[5]};

endmodule : pru_reg_bank

// [hw/pru_pin_route_unit.sv]
// pin route unit: steers peripheral signals onto port pins
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ns
`include "pru_map.svh"

module pru_pin_route_unit
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [5:0] event_val_i,
    input wire logic [5:0] event_oe_i,
    input wire logic [3:0] cell_val_i,
    input wire logic [3:0] cell_oe_i,
    input wire pru_pkg::pru_lane4_t [3:0] serial_drv_i,
    output logic [3:0][3:0] serial_in_o,
    input wire pru_pkg::pru_lane4_t sync_serial_drv_i,
    output logic [3:0] sync_serial_in_o,
    input wire pru_pkg::pru_lane4_t two_wire_host_drv_i,
    output logic [1:0] two_wire_host_in_o,
    input wire pru_pkg::pru_lane4_t two_wire_client_drv_i,
    output logic [1:0] two_wire_client_in_o,
    input wire logic [5:0] timer_a_val_i,
    input wire logic [5:0] timer_a_oe_i,
    input wire logic [3:0] timer_b_val_i,
    input wire logic [3:0] timer_b_oe_i,
    input wire logic [5:0][7:0] pin_in_i,
    output logic [5:0][7:0] pin_val_o,
    output logic [5:0][7:0] pin_oe_o
);

    // =================================================================
    // pin placement tables
    localparam logic [2:0] EV_PORT [6] = '{`PRU_PORT_A, `PRU_PORT_B, `PRU_PORT_C,
                                           `PRU_PORT_D, `PRU_PORT_E, `PRU_PORT_F};
    localparam logic [5:0] EV_HAS_ALT = 6'h0d;
    localparam logic [2:0] CELL_PORT [4] = '{`PRU_PORT_A, `PRU_PORT_C,
                                             `PRU_PORT_D, `PRU_PORT_F};
    localparam logic [2:0] SER_PORT [4] = '{`PRU_PORT_A, `PRU_PORT_C,
                                            `PRU_PORT_F, `PRU_PORT_B};
    localparam logic [2:0] SER_ALT_LANES [4] = '{3'h4, 3'h4, 3'h3, 3'h2};
    localparam logic [2:0] TB_DEF_PORT [4] = '{`PRU_PORT_A, `PRU_PORT_A,
                                               `PRU_PORT_C, `PRU_PORT_B};
    localparam logic [2:0] TB_DEF_PIN [4] = '{3'h2, 3'h3, 3'h0, 3'h5};
    localparam logic [2:0] TB_ALT_PORT [4] = '{`PRU_PORT_F, `PRU_PORT_F,
                                               `PRU_PORT_B, `PRU_PORT_C};
    localparam logic [2:0] TB_ALT_PIN [4] = '{3'h4, 3'h5, 3'h4, 3'h1};

    // =================================================================
    // register bank
    pru_pkg::pru_route_cfg_t cfg;

    pru_reg_bank u_regs
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .cfg_o(cfg)
    );

    // =================================================================
    // pin input synchroniser, first stage read only by the second
    logic [5:0][7:0] pin_meta_ff, pin_sync_ff;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_meta_ff <= '0;
            pin_sync_ff <= '0;
        end
        else
        begin
            pin_meta_ff <= pin_in_i;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    // =================================================================
    // location decode of the two-bit fields and the three-bit timer A field: port, base pin, lane count
    logic [1:0] ss_code, tw_code;
    logic [2:0] ta_code;

    assign ss_code = cfg.twosync_route[`PRU_SYNC_SER_POS +: 2];
    assign tw_code = cfg.twosync_route[`PRU_TWO_WIRE_POS +: 2];
    assign ta_code = cfg.timer_a_route[`PRU_TIMER_A_POS +: 3];

    // serial lane l of port s with code c: 1 if the lane has a pin
    function automatic logic ser_lane_on(input logic [1:0] c, input int s, input int l);
        case (c)
            pru_pkg::PRU_LOC_DEFAULT: ser_lane_on = 1'b1;
            pru_pkg::PRU_LOC_ALTERNATE_FIRST: ser_lane_on = (3'(l) < SER_ALT_LANES[s]);
            default: ser_lane_on = 1'b0;
        endcase
    endfunction : ser_lane_on

    function automatic logic [2:0] ser_lane_pin(input logic [1:0] c, input int l);
        ser_lane_pin = (c == pru_pkg::PRU_LOC_ALTERNATE_FIRST) ? `PRU_ALT_LANE_BASE + 3'(l) : 3'(l);
    endfunction : ser_lane_pin

    // =================================================================
    // drive: lowest priority first, later placements win on a clash
    logic [5:0][7:0] nxt_pin_val, nxt_pin_oe;
    logic [5:0][7:0] pin_val_ff, pin_oe_ff;

    always_comb
    begin
        logic [2:0] pin;
        logic [2:0] port;
        pin = 3'h0;
        port = 3'h0;
        nxt_pin_val = '0;
        nxt_pin_oe = '0;
        // event outputs; alternate only where the port has one
        for (int e = 0; e < 6; e++)
        begin
            pin = (cfg.event_route[e] && EV_HAS_ALT[e]) ? `PRU_EV_PIN_ALT
                                                        : `PRU_EV_PIN_DEF;
            nxt_pin_val[EV_PORT[e]][pin] = event_val_i[e];
            nxt_pin_oe[EV_PORT[e]][pin] = event_oe_i[e];
        end
        // logic cell outputs
        for (int c = 0; c < 4; c++)
        begin
            pin = cfg.cell_route[c] ? `PRU_CELL_PIN_ALT : `PRU_CELL_PIN_DEF;
            nxt_pin_val[CELL_PORT[c]][pin] = cell_val_i[c];
            nxt_pin_oe[CELL_PORT[c]][pin] = cell_oe_i[c];
        end
        // timer B outputs
        for (int t = 0; t < 4; t++)
        begin
            port = cfg.timer_b_route[t] ? TB_ALT_PORT[t] : TB_DEF_PORT[t];
            pin = cfg.timer_b_route[t] ? TB_ALT_PIN[t] : TB_DEF_PIN[t];
            nxt_pin_val[port][pin] = timer_b_val_i[t];
            nxt_pin_oe[port][pin] = timer_b_oe_i[t];
        end
        // timer A outputs, reserved codes leave them unplaced
        if (ta_code <= `PRU_TIMER_A_LAST)
        begin
            for (int t = 0; t < 6; t++)
            begin
                nxt_pin_val[ta_code][t] = timer_a_val_i[t];
                nxt_pin_oe[ta_code][t] = timer_a_oe_i[t];
            end
        end
        // serial ports, reserved code treated as unconnected
        for (int s = 0; s < 4; s++)
        begin
            for (int l = 0; l < 4; l++)
            begin
                if (ser_lane_on(cfg.serial_route[2*s +: 2], s, l))
                begin
                    pin = ser_lane_pin(cfg.serial_route[2*s +: 2], l);
                    nxt_pin_val[SER_PORT[s]][pin] = serial_drv_i[s].val[l];
                    nxt_pin_oe[SER_PORT[s]][pin] = serial_drv_i[s].oe[l];
                end
            end
        end
        // synchronous serial port
        case (ss_code)
            pru_pkg::PRU_LOC_DEFAULT: port = `PRU_PORT_A;
            pru_pkg::PRU_LOC_ALTERNATE_FIRST: port = `PRU_PORT_C;
            pru_pkg::PRU_LOC_ALTERNATE_SECOND: port = `PRU_PORT_E;
            default: port = `PRU_PORT_A;
        endcase
        if (ss_code != pru_pkg::PRU_LOC_NONE)
        begin
            for (int l = 0; l < 4; l++)
            begin
                pin = (ss_code == pru_pkg::PRU_LOC_DEFAULT) ? `PRU_ALT_LANE_BASE + 3'(l)
                                                            : 3'(l);
                nxt_pin_val[port][pin] = sync_serial_drv_i.val[l];
                nxt_pin_oe[port][pin] = sync_serial_drv_i.oe[l];
            end
        end
        // two-wire host and client pairs, highest priority
        if (tw_code != pru_pkg::PRU_LOC_NONE)
        begin
            for (int l = 0; l < 2; l++)
            begin
                pin = `PRU_TWO_WIRE_BASE + 3'(l);
                port = (tw_code == pru_pkg::PRU_LOC_ALTERNATE_SECOND) ? `PRU_PORT_C : `PRU_PORT_A;
                nxt_pin_val[port][pin] = two_wire_host_drv_i.val[l];
                nxt_pin_oe[port][pin] = two_wire_host_drv_i.oe[l];
                port = (tw_code == pru_pkg::PRU_LOC_DEFAULT) ? `PRU_PORT_C : `PRU_PORT_F;
                nxt_pin_val[port][pin] = two_wire_client_drv_i.val[l];
                nxt_pin_oe[port][pin] = two_wire_client_drv_i.oe[l];
            end
        end
    end

    // =================================================================
    // return path: synchronised pins back to the selected peripherals
    logic [3:0][3:0] nxt_ser_in, ser_in_ff;
    logic [3:0] nxt_ss_in, ss_in_ff;
    logic [1:0] nxt_twh_in, twh_in_ff, nxt_twc_in, twc_in_ff;

    always_comb
    begin
        logic [2:0] rport;
        rport = 3'h0;
        nxt_ser_in = '0;
        nxt_ss_in = '0;
        nxt_twh_in = '0;
        nxt_twc_in = '0;
        for (int s = 0; s < 4; s++)
        begin
            for (int l = 0; l < 4; l++)
            begin
                if (ser_lane_on(cfg.serial_route[2*s +: 2], s, l))
                begin
                    nxt_ser_in[s][l] = pin_sync_ff[SER_PORT[s]]
                                                 [ser_lane_pin(cfg.serial_route[2*s +: 2], l)];
                end
            end
        end
        case (ss_code)
            pru_pkg::PRU_LOC_DEFAULT: nxt_ss_in = pin_sync_ff[`PRU_PORT_A][7:4];
            pru_pkg::PRU_LOC_ALTERNATE_FIRST: nxt_ss_in = pin_sync_ff[`PRU_PORT_C][3:0];
            pru_pkg::PRU_LOC_ALTERNATE_SECOND: nxt_ss_in = pin_sync_ff[`PRU_PORT_E][3:0];
            default: nxt_ss_in = 4'h0;
        endcase
        if (tw_code != pru_pkg::PRU_LOC_NONE)
        begin
            rport = (tw_code == pru_pkg::PRU_LOC_ALTERNATE_SECOND) ? `PRU_PORT_C : `PRU_PORT_A;
            nxt_twh_in = pin_sync_ff[rport][3:2];
            rport = (tw_code == pru_pkg::PRU_LOC_DEFAULT) ? `PRU_PORT_C : `PRU_PORT_F;
            nxt_twc_in = pin_sync_ff[rport][3:2];
        end
    end

    // =================================================================
    // output registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_val_ff <= '0;
            pin_oe_ff <= '0;
            ser_in_ff <= '0;
            ss_in_ff <= '0;
            twh_in_ff <= '0;
            twc_in_ff <= '0;
        end
        else
        begin
            pin_val_ff <= nxt_pin_val;
            pin_oe_ff <= nxt_pin_oe;
            ser_in_ff <= nxt_ser_in;
            ss_in_ff <= nxt_ss_in;
            twh_in_ff <= nxt_twh_in;
            twc_in_ff <= nxt_twc_in;
        end
    end

    assign pin_val_o = pin_val_ff;
    assign pin_oe_o = pin_oe_ff;
    assign serial_in_o = ser_in_ff;
    assign sync_serial_in_o = ss_in_ff;
    assign two_wire_host_in_o = twh_in_ff;
    assign two_wire_client_in_o = twc_in_ff;

endmodule : pru_pin_route_unit

// [verif/pru_pin_route_chk.sv]
// assertions on the bus side and two-wire host placement of the pin route unit
`timescale 1ns/1ns
`include "pru_map.svh"
module pru_pin_route_chk
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire pru_pkg::pru_lane4_t two_wire_host_drv_i,
    input wire logic [5:0][7:0] pin_oe_o
);
    // ========
    // shadow of the stored routes
    localparam logic [5:0][7:0] msk_tab = {`PRU_MASK_TIMER_B, `PRU_MASK_TIMER_A,
        `PRU_MASK_TWOSYNC, `PRU_MASK_SERIAL, `PRU_MASK_CELL, `PRU_MASK_EVENT};
    logic [5:0] idx;
    logic [7:0] msk;
    logic [1:0] tw;
    logic [5:0][7:0] shd_ff;
    // decode of the word index and its implemented bits
    assign idx = wb_adr_i[7:2];
    assign msk = (idx < 6'h06) ? msk_tab[idx[2:0]] : 8'h00;
    assign tw = shd_ff[3][5:4];
    // shadow follows each answered write
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            shd_ff <= '0;
        else if (wb_ack_o && wb_we_i && wb_sel_i[0] && idx < 6'h06)
            shd_ff[idx[2:0]] <= wb_dat_i[7:0] & msk;
    end
    // ========
    // properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i;
    endsequence
    sequence s_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    AST_ACK_NEXT: assert property ($rose(wb_cyc_i) ##0 s_req |=> s_pulse)
        else $error("request not answered by a one-cycle ack");
    AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    AST_RD_MASK: assert property (wb_ack_o && !wb_we_i |-> (wb_dat_o & ~{24'h0, msk}) == 32'h0)
        else $error("unimplemented bits read nonzero");
    AST_RD_BACK: assert property (wb_ack_o && !wb_we_i && idx < 6'h06 |-> wb_dat_o[7:0] == shd_ff[idx[2:0]])
        else $error("read data differs from last write");
    AST_DAT_HOLD: assert property ($fell(wb_ack_o) |-> $stable(wb_dat_o))
        else $error("read data moved after ack");
    AST_QUIET: assert property ($fell(rst_i) |-> pin_oe_o == '0 && !wb_ack_o)
        else $error("outputs active after reset");
    AST_TW_HOST: assert property (tw == 2'h0 && $past(tw) == 2'h0 && !$past(rst_i) |->
        pin_oe_o[0][3:2] == $past(two_wire_host_drv_i.oe[1:0]))
        else $error("two-wire host not on port a");
    AST_TW_ALTERNATE_SECOND: assert property (tw == 2'h2 && $past(tw) == 2'h2 && !$past(rst_i) |->
        pin_oe_o[2][3:2] == $past(two_wire_host_drv_i.oe[1:0]))
        else $error("two-wire host not on port c");
endmodule : pru_pin_route_chk

bind pru_pin_route_unit pru_pin_route_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .two_wire_host_drv_i,
    .pin_oe_o);

// [verif/tb_top.sv]
// self-checking bench of the pin route unit
`timescale 1ns/1ns
`include "pru_map.svh"
module tb_top;
    // ========
    // stimulus, model state and counters
    localparam logic [5:0][7:0] msk_tab = {`PRU_MASK_TIMER_B, `PRU_MASK_TIMER_A,
        `PRU_MASK_TWOSYNC, `PRU_MASK_SERIAL, `PRU_MASK_CELL, `PRU_MASK_EVENT};
    localparam int cl_port [4] = '{0, 2, 3, 5};
    localparam int ser_port [4] = '{0, 2, 5, 1};
    localparam int alt_w [4] = '{4, 4, 3, 2};
    localparam int tb_pin [4][4] = '{'{0, 2, 5, 4}, '{0, 3, 5, 5}, '{2, 0, 1, 4}, '{1, 5, 2, 1}};
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic wb_ack_o;
    logic [5:0] ev_v = 6'h00, ev_o = 6'h00, ta_v = 6'h00, ta_o = 6'h00;
    logic [3:0] ce_v = 4'h0, ce_o = 4'h0, tb_v = 4'h0, tb_o = 4'h0, sy_in, sy_e;
    pru_pkg::pru_lane4_t [3:0] ser_d = '0;
    pru_pkg::pru_lane4_t sy_d = '0, th_d = '0, tc_d = '0;
    logic [5:0][7:0] pin_i = '0, pv, po, exp_v, exp_o;
    logic [3:0][3:0] ser_in, ser_e;
    logic [1:0] th_in, tc_in, th_e, tc_e;
    logic [7:0] rg [6] = '{default: 8'h00};
    logic [31:0] seed = 32'h00014fb5;
    int n_errors = 0;
    int checks = 0;
    // clock
    initial
    begin
        forever #5 clk_i = ~clk_i;
    end
    // design under test
    pru_pin_route_unit dut
    (
        .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .event_val_i(ev_v), .event_oe_i(ev_o), .cell_val_i(ce_v),
        .cell_oe_i(ce_o), .serial_drv_i(ser_d), .serial_in_o(ser_in), .sync_serial_drv_i(sy_d),
        .sync_serial_in_o(sy_in), .two_wire_host_drv_i(th_d), .two_wire_host_in_o(th_in),
        .two_wire_client_drv_i(tc_d), .two_wire_client_in_o(tc_in), .timer_a_val_i(ta_v),
        .timer_a_oe_i(ta_o), .timer_b_val_i(tb_v), .timer_b_oe_i(tb_o), .pin_in_i(pin_i),
        .pin_val_o(pv), .pin_oe_o(po)
    );
    // ========
    // helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one classic cycle, held until ack
    task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] d,
        output logic [31:0] q);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h0, d};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1)
            @(posedge clk_i);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : bus
    task automatic wr(input int i, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, 8'(4 * i), d, q);
        if (i < 6)
            rg[i] = d & msk_tab[i];
    endtask : wr
    task automatic rdc(input int i);
        logic [31:0] q;
        bus(1'b0, 8'(4 * i), 8'h00, q);
        chk(q, (i < 6) ? rg[i] : 8'h00);
    endtask : rdc
    task automatic put(input int p, input int b, input logic v, input logic o);
        exp_v[p][b] = v;
        exp_o[p][b] = o;
    endtask : put
    // routing model, lowest priority placed first
    task automatic mdl();
        int c;
        int hp;
        int cl;
        exp_v = '0;
        exp_o = '0;
        th_e = 2'h0;
        tc_e = 2'h0;
        ser_e = '0;
        sy_e = 4'h0;
        for (int i = 0; i < 6; i++)
            put(i, (rg[0][i] && i != 1 && i < 4) ? 7 : 2, ev_v[i], ev_o[i]);
        for (int i = 0; i < 4; i++)
            put(cl_port[i], rg[1][i] ? 6 : 3, ce_v[i], ce_o[i]);
        for (int i = 0; i < 4; i++)
            put(tb_pin[i][2 * rg[5][i]], tb_pin[i][2 * rg[5][i] + 1], tb_v[i], tb_o[i]);
        for (int i = 0; i < 6 && rg[4] < 8'h06; i++)
            put(rg[4], i, ta_v[i], ta_o[i]);
        for (int n = 0; n < 4; n++)
            for (int l = 0; l < 4; l++)
            begin
                c = rg[2][2 * n +: 2];
                if (c == 0 || (c == 1 && l < alt_w[n]))
                begin
                    put(ser_port[n], l + 4 * c, ser_d[n].val[l], ser_d[n].oe[l]);
                    ser_e[n][l] = pin_i[ser_port[n]][l + 4 * c];
                end
            end
        c = rg[3][1:0];
        for (int l = 0; l < 4 && c < 3; l++)
        begin
            put(2 * c, l + ((c == 0) ? 4 : 0), sy_d.val[l], sy_d.oe[l]);
            sy_e[l] = pin_i[2 * c][l + ((c == 0) ? 4 : 0)];
        end
        c = rg[3][5:4];
        hp = (c == 2) ? 2 : 0;
        cl = (c == 0) ? 2 : 5;
        for (int l = 0; l < 2 && c < 3; l++)
        begin
            put(hp, 2 + l, th_d.val[l], th_d.oe[l]);
            put(cl, 2 + l, tc_d.val[l], tc_d.oe[l]);
            th_e[l] = pin_i[hp][2 + l];
            tc_e[l] = pin_i[cl][2 + l];
        end
    endtask : mdl
    task automatic final_report();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report
    // ========
    // main sequence
    initial
    begin
        logic [7:0] r;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 7; i++)
            rdc(i);
        for (int k = 0; k < 40; k++)
        begin
            r = 8'(rnd());
            wr(0, r & 8'hcd);
            wr(1, 8'(rnd()));
            r = 8'(rnd());
            wr(2, r | ((r >> 1) & 8'h55));
            r = 8'(rnd());
            wr(3, {r[7:6], ((r[5:4] == 2'h3) ? 2'h1 : r[5:4]), r[3:0]});
            r = 8'(rnd());
            wr(4, {r[7:3], 3'(r[2:0] % 3'h6)});
            wr(5, 8'(rnd()));
            wr(6 + (k * 7) % 58, 8'(rnd()));
            {ev_v, ev_o, ta_v, ta_o} <= 24'(rnd());
            {ce_v, ce_o, tb_v, tb_o} <= 16'(rnd());
            ser_d <= rnd();
            {sy_d, th_d, tc_d} <= 24'(rnd());
            pin_i <= 48'({rnd(), rnd()});
            repeat (5) @(posedge clk_i);
            mdl();
            chk(po, exp_o);
            chk(pv, exp_v);
            chk({th_in, tc_in}, {th_e, tc_e});
            chk(ser_in, ser_e);
            chk(sy_in, sy_e);
            for (int i = 0; i < 7; i++)
                rdc(i);
        end
        final_report();
    end
    // watchdog against a hung handshake
    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        final_report();
    end
endmodule : tb_top
